// ==== pae_core.v ====
// Program-counter, stack-frame and data-address extension unit
`timescale 1ns/1ps
`default_nettype none
`include "pae_regs.vh"

module pae_core (
    // Clock and reset
    input wire clk,
    input wire srst,
    // Software configuration writes
    input wire cfg_wr,
    input wire [2:0] cfg_sel,
    input wire [7:0] cfg_wdata,
    input wire dp_wr,
    input wire dp_wsel,
    input wire [15:0] dp_wdata,
    input wire dp_select,
    input wire sp_wr,
    input wire [7:0] sp_wdata,
    // Memory assignment bits
    input wire can_memory_assign,
    input wire internal_memory_config_hi,
    // Operands from the core
    input wire [7:0] port_two_latch,
    input wire [7:0] ri_value,
    input wire [7:0] acc_value,
    // Instruction request
    input wire op_valid,
    input wire [3:0] op_code,
    input wire [2:0] op_len,
    input wire [23:0] op_target,
    // Stack read data
    input wire [7:0] stk_rdata,
    // Instruction status
    output reg op_ready,
    output reg op_done,
    output reg [2:0] op_cycles,
    output reg [1:0] mode_active,
    output reg [1:0] mode_request,
    output reg [1:0] int_depth,
    // Architectural state
    output reg [23:0] pc,
    output reg [7:0] sp,
    output reg [7:0] code_page_reg,
    output reg [7:0] pointer0_extension,
    output reg [7:0] pointer1_extension,
    output reg [7:0] indirect_move_upper_addr,
    output reg [15:0] dp0,
    output reg [15:0] dp1,
    // Memory bus addresses
    output reg [23:0] xdata_addr,
    output reg xdata_strobe,
    output reg [23:0] code_addr,
    output reg code_strobe,
    // Stack memory
    output reg stk_we,
    output reg stk_re,
    output reg [7:0] stk_addr,
    output reg [7:0] stk_wdata
);

    reg [1:0] state;
    reg [1:0] cnt;
    reg [1:0] nbytes_q;
    reg [23:0] save;
    reg [23:0] tgt_q;
    reg [3:0] op_q;
    reg pop_phase;

    reg [1:0] cur_mode;
    reg m16;
    reg paged;
    reg contig;
    reg [15:0] low_inc;
    reg [23:0] seq_pc;
    reg [7:0] load_page;
    reg [15:0] sel_dp;
    reg [7:0] sel_ext;
    reg [23:0] tgt;
    reg [1:0] nbytes;
    reg [2:0] cyc;
    reg [7:0] mx_hi;
    reg [23:0] ri_addr;
    reg [23:0] dp_addr;
    reg [23:0] tbl_addr;
    reg [16:0] dp_sum;

    wire accept;
    assign accept = op_valid && op_ready && (state == `PAE_ST_IDLE);

    always @* begin
        // mode latch: request seen only between instructions
        cur_mode = (state == `PAE_ST_IDLE) ? mode_request : mode_active;
        m16 = (cur_mode == `PAE_MODE_16);
        paged = (cur_mode == `PAE_MODE_PAGED);
        contig = cur_mode[1];
        sel_dp = dp_select ? dp1 : dp0;
        sel_ext = dp_select ? pointer1_extension : pointer0_extension;
        low_inc = pc[15:0] + {13'h0000, op_len};
        seq_pc = contig ? (pc + {21'h000000, op_len}) : {pc[23:16], low_inc};
        load_page = paged ? code_page_reg : `PAE_VEC_PAGE;
        tbl_addr = contig ? ({sel_ext, sel_dp} + {16'h0000, acc_value})
                          : {pc[23:16], sel_dp + {8'h00, acc_value}};
        case (op_code)
            `PAE_OP_LJMP, `PAE_OP_LCALL: begin
                tgt = contig ? op_target : {load_page, op_target[15:0]};
            end
            `PAE_OP_AJMP: begin
                tgt = contig ? {seq_pc[23:19], op_target[18:0]}
                             : {seq_pc[23:11], op_target[10:0]};
            end
            `PAE_OP_ACALL: begin
                tgt = contig ? {seq_pc[23:19], op_target[18:0]}
                             : {load_page, seq_pc[15:11], op_target[10:0]};
            end
            `PAE_OP_INTR: begin
                tgt = {`PAE_VEC_PAGE, op_target[15:0]};
            end
            `PAE_OP_JMPA: begin
                tgt = tbl_addr;
            end
            default: begin
                tgt = seq_pc;
            end
        endcase
        nbytes = m16 ? `PAE_FRAME_16 : `PAE_FRAME_EXT;
        case (op_code)
            `PAE_OP_ACALL: begin
                cyc = contig ? `PAE_CYC_C_ACALL
                             : (paged ? `PAE_CYC_ACALL + `PAE_CYC_EXTRA : `PAE_CYC_ACALL);
            end
            `PAE_OP_LCALL: begin
                cyc = contig ? `PAE_CYC_C_LCALL
                             : (paged ? `PAE_CYC_LCALL + `PAE_CYC_EXTRA : `PAE_CYC_LCALL);
            end
            `PAE_OP_RET, `PAE_OP_RETI: begin
                cyc = m16 ? `PAE_CYC_RET : `PAE_CYC_RET + `PAE_CYC_EXTRA;
            end
            `PAE_OP_INTR: begin
                cyc = m16 ? `PAE_CYC_INTR : `PAE_CYC_INTR + `PAE_CYC_EXTRA;
            end
            `PAE_OP_LJMP: begin
                cyc = contig ? `PAE_CYC_C_LJMP : `PAE_CYC_LJMP;
            end
            `PAE_OP_AJMP: begin
                cyc = contig ? `PAE_CYC_C_AJMP : `PAE_CYC_OTHER;
            end
            default: begin
                cyc = `PAE_CYC_OTHER;
            end
        endcase
        mx_hi = indirect_move_upper_addr &
                ((can_memory_assign | internal_memory_config_hi) ? `PAE_MASK_23 : `PAE_MASK_22);
        ri_addr = m16 ? {8'h00, port_two_latch, ri_value}
                      : {mx_hi, port_two_latch, ri_value};
        // pointer form skips latch and upper register
        dp_addr = m16 ? {8'h00, sel_dp} : {sel_ext, sel_dp};
        dp_sum = {1'b0, sel_dp} + 17'h00001;
    end

    always @(posedge clk) begin
        if (srst) begin
            state <= `PAE_ST_IDLE;
            cnt <= 2'h0;
            nbytes_q <= 2'h0;
            save <= `PAE_PC_RST;
            tgt_q <= `PAE_PC_RST;
            op_q <= `PAE_OP_NEXT;
            pop_phase <= 1'b0;
            op_ready <= 1'b1;
            op_done <= 1'b0;
            op_cycles <= 3'h0;
            mode_active <= `PAE_MODE_RST;
            mode_request <= `PAE_MODE_RST;
            int_depth <= 2'h0;
            pc <= `PAE_PC_RST;
            sp <= `PAE_SP_RST;
            code_page_reg <= `PAE_BYTE_RST;
            pointer0_extension <= `PAE_BYTE_RST;
            pointer1_extension <= `PAE_BYTE_RST;
            indirect_move_upper_addr <= `PAE_BYTE_RST;
            dp0 <= `PAE_DP_RST;
            dp1 <= `PAE_DP_RST;
            xdata_addr <= 24'h000000;
            xdata_strobe <= 1'b0;
            code_addr <= 24'h000000;
            code_strobe <= 1'b0;
            stk_we <= 1'b0;
            stk_re <= 1'b0;
            stk_addr <= 8'h00;
            stk_wdata <= 8'h00;
        end else begin
            op_done <= 1'b0;
            xdata_strobe <= 1'b0;
            code_strobe <= 1'b0;
            stk_we <= 1'b0;
            stk_re <= 1'b0;
            if (dp_wr) begin
                if (dp_wsel) begin
                    dp1 <= dp_wdata;
                end else begin
                    dp0 <= dp_wdata;
                end
            end
            if (sp_wr && state == `PAE_ST_IDLE && !accept) begin
                sp <= sp_wdata;
            end
            case (state)
                `PAE_ST_IDLE: begin
                    if (accept) begin
                        mode_active <= cur_mode;
                        op_q <= op_code;
                        op_cycles <= cyc;
                        nbytes_q <= nbytes;
                        tgt_q <= tgt;
                        case (op_code)
                            `PAE_OP_ACALL, `PAE_OP_LCALL, `PAE_OP_INTR: begin
                                save <= (op_code == `PAE_OP_INTR) ? pc : seq_pc;
                                cnt <= 2'h0;
                                op_ready <= 1'b0;
                                state <= `PAE_ST_PUSH;
                            end
                            `PAE_OP_RET, `PAE_OP_RETI: begin
                                tgt_q <= 24'h000000;
                                cnt <= nbytes - 2'h1;
                                pop_phase <= 1'b0;
                                op_ready <= 1'b0;
                                state <= `PAE_ST_POP;
                            end
                            `PAE_OP_MOVX_RI, `PAE_OP_MOVX_DP: begin
                                xdata_addr <= (op_code == `PAE_OP_MOVX_RI) ? ri_addr : dp_addr;
                                xdata_strobe <= 1'b1;
                                pc <= seq_pc;
                                op_done <= 1'b1;
                            end
                            `PAE_OP_MOVC: begin
                                code_addr <= tbl_addr;
                                code_strobe <= 1'b1;
                                pc <= seq_pc;
                                op_done <= 1'b1;
                            end
                            `PAE_OP_DPINC: begin
                                if (dp_select) begin
                                    dp1 <= dp_sum[15:0];
                                end else begin
                                    dp0 <= dp_sum[15:0];
                                end
                                // carry reaches extension only when contiguous
                                if (contig && dp_sum[16]) begin
                                    if (dp_select) begin
                                        pointer1_extension <= pointer1_extension + 8'h01;
                                    end else begin
                                        pointer0_extension <= pointer0_extension + 8'h01;
                                    end
                                end
                                pc <= seq_pc;
                                op_done <= 1'b1;
                            end
                            default: begin
                                // plain forms keep the page in paged mode, except LJMP which loads code_page_reg
                                pc <= tgt;
                                op_done <= 1'b1;
                            end
                        endcase
                    end
                end
                `PAE_ST_PUSH: begin
                    // pre-increment then write, low byte first
                    stk_we <= 1'b1;
                    stk_addr <= sp + 8'h01;
                    sp <= sp + 8'h01;
                    stk_wdata <= save[cnt * 8 +: 8];
                    cnt <= cnt + 2'h1;
                    if (cnt == nbytes_q - 2'h1) begin
                        state <= `PAE_ST_FIN;
                    end
                end
                `PAE_ST_POP: begin
                    // highest byte first, decrement after each
                    if (!pop_phase) begin
                        stk_re <= 1'b1;
                        stk_addr <= sp;
                        sp <= sp - 8'h01;
                        pop_phase <= 1'b1;
                    end else begin
                        tgt_q[cnt * 8 +: 8] <= stk_rdata;
                        pop_phase <= 1'b0;
                        cnt <= cnt - 2'h1;
                        if (cnt == 2'h0) begin
                            state <= `PAE_ST_FIN;
                        end
                    end
                end
                default: begin
                    pc <= tgt_q;
                    op_done <= 1'b1;
                    op_ready <= 1'b1;
                    state <= `PAE_ST_IDLE;
                    if (op_q == `PAE_OP_INTR && int_depth != `PAE_MAX_NEST) begin
                        int_depth <= int_depth + 2'h1;
                    end else if (op_q == `PAE_OP_RETI && int_depth != 2'h0) begin
                        int_depth <= int_depth - 2'h1;
                    end
                end
            endcase
            // Configuration writes land last so they win over hardware updates; dp_wr writes land first and lose to DPINC
            if (cfg_wr) begin
                case (cfg_sel)
                    `PAE_CFG_MODE: begin
                        mode_request <= cfg_wdata[1:0];
                    end
                    `PAE_CFG_PAGE: begin
                        code_page_reg <= cfg_wdata;
                    end
                    `PAE_CFG_EXT0: begin
                        pointer0_extension <= cfg_wdata;
                    end
                    `PAE_CFG_EXT1: begin
                        pointer1_extension <= cfg_wdata;
                    end
                    `PAE_CFG_UPPER: begin
                        indirect_move_upper_addr <= cfg_wdata;
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

endmodule // pae_core
`default_nettype wire

// ==== pae_regs.vh ====
// Constants for the paged address extension unit
`ifndef PAE_REGS_VH
`define PAE_REGS_VH

// Address mode field values
`define PAE_MODE_16 2'h0
`define PAE_MODE_PAGED 2'h1
`define PAE_MODE_RST 2'h0

// Instruction classes presented by the core
`define PAE_OP_NEXT 4'h0
`define PAE_OP_LJMP 4'h1
`define PAE_OP_AJMP 4'h2
`define PAE_OP_ACALL 4'h3
`define PAE_OP_LCALL 4'h4
`define PAE_OP_RET 4'h5
`define PAE_OP_RETI 4'h6
`define PAE_OP_INTR 4'h7
`define PAE_OP_JMPA 4'h8
`define PAE_OP_MOVC 4'h9
`define PAE_OP_MOVX_RI 4'hA
`define PAE_OP_MOVX_DP 4'hB
`define PAE_OP_DPINC 4'hC

// Configuration write selects
`define PAE_CFG_MODE 3'h0
`define PAE_CFG_PAGE 3'h1
`define PAE_CFG_EXT0 3'h2
`define PAE_CFG_EXT1 3'h3
`define PAE_CFG_UPPER 3'h4

// Reset values
`define PAE_PC_RST 24'h000000
`define PAE_SP_RST 8'h07
`define PAE_BYTE_RST 8'h00
`define PAE_DP_RST 16'h0000

// Memory-width masks for register-indirect data moves
`define PAE_MASK_22 8'h3F
`define PAE_MASK_23 8'h7F

// Interrupt vector page and nesting limit
`define PAE_VEC_PAGE 8'h00
`define PAE_MAX_NEST 2'h3

// Stack frame lengths in bytes
`define PAE_FRAME_16 2'h2
`define PAE_FRAME_EXT 2'h3

// Machine cycles in 16-bit mode
`define PAE_CYC_ACALL 3'h3
`define PAE_CYC_LCALL 3'h4
`define PAE_CYC_RET 3'h4
`define PAE_CYC_INTR 3'h4
`define PAE_CYC_LJMP 3'h4
`define PAE_CYC_OTHER 3'h1
// Extra machine cycle outside 16-bit mode (for RET, RETI and INTR in every such mode; for ACALL and LCALL in paged mode only)
`define PAE_CYC_EXTRA 3'h1
// Contiguous-mode cycles for extended operand forms
`define PAE_CYC_C_ACALL 3'h5
`define PAE_CYC_C_AJMP 3'h5
`define PAE_CYC_C_LCALL 3'h6
`define PAE_CYC_C_LJMP 3'h5

// Sequencer states
`define PAE_ST_IDLE 2'h0
`define PAE_ST_PUSH 2'h1
`define PAE_ST_POP 2'h2
`define PAE_ST_FIN 2'h3

`endif

// ==== pae_stack_mem.sv ====
// Behavioural stack memory facing the unit's stack port
`timescale 1ns/1ps
`default_nettype none
module pae_stack_mem (
    // Clock
    input wire logic clk,
    // Stack port
    input wire logic stk_we,
    input wire logic stk_re,
    input wire logic [7:0] stk_addr,
    input wire logic [7:0] stk_wdata,
    output logic [7:0] stk_rdata
);
    logic [7:0] mem [0:255];
    logic [7:0] last;
    initial last = 8'h00;
    always @(posedge clk) begin
        if (stk_we)
            mem[stk_addr] <= stk_wdata;
        if (stk_re)
            last <= mem[stk_addr];
    end
    // read on request
    // Idle port shows inverted last read, so stale data never matches
    assign stk_rdata = stk_re ? mem[stk_addr] : ~last;
endmodule // pae_stack_mem
`default_nettype wire

// ==== pae_chk_asserts.sv ====
// Port-level checks for the paged address extension unit
`timescale 1ns/1ps
`default_nettype none
`include "pae_regs.vh"
module pae_chk (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Watched inputs
    input wire logic cfg_wr,
    input wire logic dp_select,
    input wire logic can_memory_assign,
    input wire logic internal_memory_config_hi,
    input wire logic [7:0] port_two_latch,
    input wire logic [7:0] ri_value,
    input wire logic [7:0] acc_value,
    input wire logic op_valid,
    input wire logic [3:0] op_code,
    input wire logic [2:0] op_len,
    input wire logic [23:0] op_target,
    // Watched outputs
    input wire logic op_ready,
    input wire logic op_done,
    input wire logic [1:0] mode_active,
    input wire logic [1:0] mode_request,
    input wire logic [23:0] pc,
    input wire logic [7:0] code_page_reg,
    input wire logic [7:0] pointer0_extension,
    input wire logic [7:0] pointer1_extension,
    input wire logic [7:0] indirect_move_upper_addr,
    input wire logic [15:0] dp0,
    input wire logic [15:0] dp1,
    input wire logic [23:0] xdata_addr,
    input wire logic xdata_strobe,
    input wire logic stk_we,
    input wire logic stk_re,
    input wire logic [7:0] stk_addr,
    input wire logic [7:0] stk_wdata
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    wire take = op_valid && op_ready;
    wire paged = mode_request == `PAE_MODE_PAGED;
    sequence pop_three;
        stk_re ##1 !stk_re ##1 stk_re ##1 !stk_re ##1 stk_re ##1 !stk_re;
    endsequence
    reset_mode_a: assert property (disable iff (1'b0) srst ##1 !srst |->
        mode_request == `PAE_MODE_16 && mode_active == `PAE_MODE_16 && pc == `PAE_PC_RST)
        else $error("state not at reset values");
    paged_call_a: assert property (take && paged && op_code == `PAE_OP_LCALL |->
        ##2 (stk_we && stk_wdata == $past(pc[7:0], 2) + $past(op_len, 2)) ##1 stk_we
        ##1 (stk_we && stk_wdata == $past(pc[23:16], 4)) ##1 (op_done
        && pc == {$past(code_page_reg, 5), $past(op_target[15:0], 5)}))
        else $error("paged call frame or target wrong");
    push_addr_a: assert property (stk_we && $past(stk_we) |->
        stk_addr == $past(stk_addr) + 8'h01) else $error("push address not incremented");
    reti_pop_a: assert property (take && paged && op_code == `PAE_OP_RETI |->
        ##2 pop_three ##1 op_done) else $error("paged return sequence wrong");
    pop_addr_a: assert property (stk_re && $past(stk_re, 2) |->
        stk_addr == $past(stk_addr, 2) - 8'h01) else $error("pop address not decremented");
    vec_page_a: assert property (take && paged && op_code == `PAE_OP_INTR |->
        ##5 (op_done && pc == {`PAE_VEC_PAGE, $past(op_target[15:0], 5)}))
        else $error("vector not on page zero");
    ind_move_a: assert property (take && paged && op_code == `PAE_OP_MOVX_RI |=>
        xdata_strobe && xdata_addr == {$past(indirect_move_upper_addr) & (($past(
        can_memory_assign) || $past(internal_memory_config_hi)) ? `PAE_MASK_23 : `PAE_MASK_22),
        $past(port_two_latch), $past(ri_value)}) else $error("indirect move address wrong");
    ptr_move_a: assert property (take && paged && op_code == `PAE_OP_MOVX_DP |=>
        xdata_strobe && xdata_addr == ($past(dp_select) ? {$past(pointer1_extension),
        $past(dp1)} : {$past(pointer0_extension), $past(dp0)}))
        else $error("pointer move address wrong");
    page_hold_a: assert property (take && paged && op_code == `PAE_OP_NEXT |=>
        op_done && pc[23:16] == $past(pc[23:16]) && pc[15:0] == $past(pc[15:0]) + $past(op_len))
        else $error("page byte moved on increment");
    idx_jump_a: assert property (take && paged && op_code == `PAE_OP_JMPA |=>
        pc == {$past(pc[23:16]), $past(acc_value) + ($past(dp_select) ? $past(dp1) : $past(dp0))})
        else $error("indexed jump left the page");
    mode_take_a: assert property (take |=> mode_active == $past(mode_request))
        else $error("mode not latched at accept");
    mode_hold_a: assert property (!op_ready && !$past(op_ready) |-> $stable(mode_active))
        else $error("mode changed mid instruction");
    ext_keep_a: assert property (take && paged && !cfg_wr && op_code == `PAE_OP_DPINC
        |=> $stable(pointer0_extension) && $stable(pointer1_extension))
        else $error("pointer extension took a carry");
endmodule // pae_chk
`default_nettype wire

// ==== pae_tb.sv ====
// Self-checking bench for the paged address extension unit
`timescale 1ns/1ps
`default_nettype none
`include "pae_regs.vh"
module tb;
    logic clk, srst, cfg_wr, dp_wr, dp_wsel, dp_select, sp_wr, asg, idm, op_valid;
    logic [2:0] cfg_sel, op_len;
    logic [7:0] cfg_wdata, sp_wdata, ptl, ri, acc, sv;
    logic [15:0] dp_wdata;
    logic [3:0] op_code;
    logic [23:0] op_target, mpc;
    wire op_ready, op_done, xs, cs, we, re;
    wire [2:0] cyc;
    wire [1:0] ma, mr, dep;
    wire [23:0] pc, xa, ca;
    wire [7:0] sp, pg, x0, x1, mx, sa, sd, stk_rdata;
    wire [15:0] d0, d1;
    integer miscompares = 0, n_compared = 0, i;
    logic [7:0] msp, mpg, mx0, mx1, mmx;
    logic [15:0] md0, md1;
    logic [1:0] mmode, mdep;
    logic [23:0] stkq[$];
    pae_core DUT (.clk, .srst, .cfg_wr, .cfg_sel, .cfg_wdata, .dp_wr, .dp_wsel, .dp_wdata,
        .dp_select, .sp_wr, .sp_wdata, .can_memory_assign(asg), .internal_memory_config_hi(idm),
        .port_two_latch(ptl), .ri_value(ri), .acc_value(acc), .op_valid, .op_code, .op_len,
        .op_target, .stk_rdata, .op_ready, .op_done, .op_cycles(cyc), .mode_active(ma),
        .mode_request(mr), .int_depth(dep), .pc, .sp, .code_page_reg(pg),
        .pointer0_extension(x0), .pointer1_extension(x1), .indirect_move_upper_addr(mx),
        .dp0(d0), .dp1(d1), .xdata_addr(xa), .xdata_strobe(xs), .code_addr(ca),
        .code_strobe(cs), .stk_we(we), .stk_re(re), .stk_addr(sa), .stk_wdata(sd));
    pae_stack_mem u_mem (.clk, .stk_we(we), .stk_re(re), .stk_addr(sa), .stk_wdata(sd),
        .stk_rdata);
    initial begin
        clk = 0;
        forever #5 clk = ~clk;
    end
    task chk(input logic [47:0] got, input logic [47:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task give_verdict;
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task do_reset;
        srst = 1;
        repeat (10) @(posedge clk);
        #1 srst = 0;
        {mpc, msp} = {`PAE_PC_RST, `PAE_SP_RST};
        {mpg, mx0, mx1, mmx, md0, md1, mmode, mdep} = '0;
        stkq.delete();
    endtask
    task cfg(input logic [2:0] s, input logic [7:0] d);
        @(posedge clk) #1;
        {cfg_wr, cfg_sel, cfg_wdata} = {1'b1, s, d};
        @(posedge clk) #1;
        cfg_wr = 0;
        case (s)
            `PAE_CFG_MODE: mmode = d[1:0];
            `PAE_CFG_PAGE: mpg = d;
            `PAE_CFG_EXT0: mx0 = d;
            `PAE_CFG_EXT1: mx1 = d;
            `PAE_CFG_UPPER: mmx = d;
            default: ;
        endcase
    endtask
    task dpw(input logic s, input logic [15:0] d);
        @(posedge clk) #1;
        {dp_wr, dp_wsel, dp_wdata} = {1'b1, s, d};
        @(posedge clk) #1;
        dp_wr = 0;
        if (s)
            md1 = d;
        else
            md0 = d;
    endtask
    function automatic [2:0] exp_cyc(input logic [3:0] c);
        logic [2:0] x;
        x = (mmode == `PAE_MODE_PAGED) ? `PAE_CYC_EXTRA : 3'h0;
        case (c)
            `PAE_OP_ACALL: exp_cyc = mmode[1] ? `PAE_CYC_C_ACALL : `PAE_CYC_ACALL + x;
            `PAE_OP_LCALL: exp_cyc = mmode[1] ? `PAE_CYC_C_LCALL : `PAE_CYC_LCALL + x;
            `PAE_OP_RET, `PAE_OP_RETI: exp_cyc = `PAE_CYC_RET + x;
            `PAE_OP_INTR: exp_cyc = `PAE_CYC_INTR + x;
            `PAE_OP_LJMP: exp_cyc = mmode[1] ? `PAE_CYC_C_LJMP : `PAE_CYC_LJMP;
            `PAE_OP_AJMP: exp_cyc = mmode[1] ? `PAE_CYC_C_AJMP : `PAE_CYC_OTHER;
            default: exp_cyc = `PAE_CYC_OTHER;
        endcase
    endfunction
    task op(input logic [3:0] c, input logic [2:0] l, input logic [23:0] t);
        integer n, lat, nb;
        logic [23:0] e, r;
        logic [15:0] dp;
        nb = (mmode == `PAE_MODE_16) ? 2 : 3;
        dp = dp_select ? md1 : md0;
        r = mmode[1] ? mpc + 24'(l) : {mpc[23:16], mpc[15:0] + 16'(l)};
        e = r;
        lat = 1;
        @(posedge clk) #1;
        {op_valid, op_code, op_len, op_target} = {1'b1, c, l, t};
        {acc, ptl, ri} = 24'($urandom);
        case (c)
            `PAE_OP_LJMP: e = mmode[1] ? t : {mpg, t[15:0]};
            `PAE_OP_AJMP: e = mmode[1] ? {r[23:19], t[18:0]} : {r[23:11], t[10:0]};
            `PAE_OP_ACALL, `PAE_OP_LCALL, `PAE_OP_INTR: begin
                stkq.push_back(r);
                msp = msp + 8'(nb);
                lat = nb + 2;
                e = (c == `PAE_OP_ACALL) ? {mpg, r[15:11], t[10:0]} : {mpg, t[15:0]};
                if (c == `PAE_OP_INTR)
                    {e, mdep} = {`PAE_VEC_PAGE, t[15:0], mdep + 2'(mdep != `PAE_MAX_NEST)};
            end
            `PAE_OP_RET, `PAE_OP_RETI: begin
                e = stkq.pop_back();
                msp = msp - 8'(nb);
                lat = 2 * nb + 2;
                mdep = mdep - 2'(c == `PAE_OP_RETI);
            end
            `PAE_OP_JMPA: e = {mpc[23:16], acc + dp};
            default: ;
        endcase
        @(posedge clk) #1;
        op_valid = 0;
        for (n = 1; op_done !== 1'b1 && n < 20; n++)
            @(posedge clk) #1;
        if (c == `PAE_OP_DPINC)
            {md1, md0} = dp_select ? {md1 + 16'h1, md0} : {md1, md0 + 16'h1};
        chk(n, lat);
        chk(pc, e);
        chk(sp, msp);
        chk(cyc, exp_cyc(c));
        chk({ma, dep}, {mmode, mdep});
        if (c == `PAE_OP_MOVX_RI)
            chk({xs, xa}, {1'b1, mmx & ((asg || idm) ? `PAE_MASK_23 : `PAE_MASK_22), ptl, ri});
        if (c == `PAE_OP_MOVX_DP)
            chk({xs, xa}, {1'b1, dp_select ? mx1 : mx0, dp});
        if (c == `PAE_OP_MOVC)
            chk({cs, ca}, {1'b1, mpc[23:16], acc + dp});
        if (c == `PAE_OP_DPINC)
            chk({x0, x1, d0, d1}, {mx0, mx1, md0, md1});
        mpc = e;
        if (n >= 20)
            give_verdict;
    endtask
    initial begin
        {cfg_wr, dp_wr, dp_wsel, dp_select, sp_wr, asg, idm, op_valid} = '0;
        {cfg_sel, op_len, cfg_wdata, sp_wdata, ptl, ri, acc, dp_wdata, op_code, op_target} = '0;
        void'($urandom(4226));
        do_reset;
        chk({mr, pc, sp}, {`PAE_MODE_16, `PAE_PC_RST, `PAE_SP_RST});
        op(`PAE_OP_LCALL, 3'h3, 24'($urandom));
        op(`PAE_OP_ACALL, 3'h2, 24'($urandom));
        op(`PAE_OP_RET, 3'h1, 24'h0);
        op(`PAE_OP_RET, 3'h1, 24'h0);
        op(`PAE_OP_LJMP, 3'h3, 24'($urandom));
        cfg(`PAE_CFG_MODE, {6'h0, `PAE_MODE_PAGED});
        chk(mr, `PAE_MODE_PAGED);
        for (i = 1; i < 6; i++)
            cfg(3'(i), 8'($urandom));
        dpw(1'b0, 16'($urandom));
        dpw(1'b1, 16'hFFFF);
        op(`PAE_OP_LJMP, 3'h3, 24'h00FFFE);
        op(`PAE_OP_NEXT, 3'h3, 24'h0);
        op(`PAE_OP_AJMP, 3'h2, 24'($urandom));
        for (i = 0; i < 2; i++) begin
            dp_select = i[0];
            op(`PAE_OP_MOVX_DP, 3'h1, 24'h0);
            op(`PAE_OP_JMPA, 3'h1, 24'h0);
            op(`PAE_OP_MOVC, 3'h1, 24'h0);
            op(`PAE_OP_DPINC, 3'h1, 24'h0);
            op(`PAE_OP_MOVX_DP, 3'h1, 24'h0);
        end
        for (i = 0; i < 4; i++) begin
            {asg, idm} = 2'(i);
            op(`PAE_OP_MOVX_RI, 3'h1, 24'h0);
        end
        op(`PAE_OP_LCALL, 3'h3, 24'($urandom));
        op(`PAE_OP_ACALL, 3'h2, 24'($urandom));
        repeat (3) begin
            op(`PAE_OP_INTR, 3'h0, 24'($urandom));
            sv = mpg;
            cfg(`PAE_CFG_PAGE, ~sv);
            op(`PAE_OP_LJMP, 3'h3, 24'($urandom));
            cfg(`PAE_CFG_PAGE, sv);
        end
        repeat (3) op(`PAE_OP_RETI, 3'h1, 24'h0);
        repeat (2) op(`PAE_OP_RET, 3'h1, 24'h0);
        cfg(`PAE_CFG_MODE, 8'h02);
        op(`PAE_OP_LJMP, 3'h4, 24'h01FFFF);
        op(`PAE_OP_NEXT, 3'h1, 24'h0);
        do_reset;
        chk({mr, ma, pc, sp}, {`PAE_MODE_16, `PAE_MODE_16, `PAE_PC_RST, `PAE_SP_RST});
        give_verdict;
    end
endmodule // tb
bind pae_core pae_chk u_chk (.clk, .srst, .cfg_wr, .dp_select, .can_memory_assign,
    .internal_memory_config_hi, .port_two_latch, .ri_value, .acc_value, .op_valid, .op_code,
    .op_len, .op_target, .op_ready, .op_done, .mode_active, .mode_request, .pc, .code_page_reg,
    .pointer0_extension, .pointer1_extension, .indirect_move_upper_addr, .dp0, .dp1,
    .xdata_addr, .xdata_strobe, .stk_we, .stk_re, .stk_addr, .stk_wdata);
`default_nettype wire
